// ### core/cfg_byte_reg.v
`timescale 1ns/1ns
`default_nettype none

module cfg_byte_reg #(
    parameter [7:0] RESET_VAL = 8'h00,
    parameter [7:0] WMASK     = 8'hFF
) (
    input  wire       hclk,     // Bus clock
    input  wire       hresetn,  // Async reset, active low
    input  wire       ce,       // Clock enable
    input  wire       we,       // Write strobe
    input  wire [7:0] wdata,    // Write byte
    output wire [7:0] q_next,   // Value after this edge
    output reg  [7:0] q         // Stored value
);

    // Read-only bits keep their reset value whatever is written
    assign q_next = we ? ((wdata & WMASK) | (q & ~WMASK)) : q;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= RESET_VAL;
        end else if (ce) begin
            q <= q_next;
        end
    end

endmodule

`default_nettype wire

// ### core/output_two_config_regs.v
// Functional notes
// R1 - The first config register lives at index 0x6C and resets to 0x20.
// R2 - The second config register lives at index 0x6D and resets to 0x20.
// R3 - First register bits 7:6 pick the positive pin driver: line, headphone, 4 ohm, FD receiver.
// R4 - Second register bits 7:6 pick the negative pin driver with the same codes, reset zero.
// R5 - First register bits 5:3 set the positive level: 2=+12,3=+6,4=0,5=-6,6=-12 dB, rest reserved.
// R6 - Second register bits 5:3 set the negative level with the same codes.
// R7 - Software uses +12 dB only when the output source is bypass only.
// R8 - Software uses +6 and -6 dB only with bypass or mixed source.
// R9 - Software uses -12 dB only with bypass or mixed source and the 4.4 kohm bypass impedance.
// R10 - First register bit 2 picks the negative bypass impedance, 0 is 4.4k and 1 is 20k.
// R11 - Second register bit 2 picks the positive bypass impedance, 0 is 4.4k and 1 is 20k.
// R12 - First register bit 1 picks differential (0) or single-ended (1) bypass input.
// R13 - First register bit 0 picks the second DAC channel bandwidth, 24 kHz or 96 kHz.
// R14 - Second register bit 0 picks AC-only (0) or AC/DC (1) coupling tolerance.
// R15 - Second register bit 1 is reserved, reads zero and is never written.
// R16 - Output source codes are 1 DAC, 2 bypass, 3 mix, 4 and 5 independent routing.
// R17 - Both registers read back their fields and writes touch nothing else; a second register write with bit 1 set also sets status bit 4.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "out_two_defs.vh"

module output_two_config_regs (
    input  wire        hclk,                           // Bus clock, 25 MHz
    input  wire        hresetn,                        // Async reset, active low
    input  wire        ce,                             // Clock enable, freezes state
    input  wire        hsel,                           // Slave select
    input  wire [31:0] haddr,                          // Byte address
    input  wire [1:0]  htrans,                         // Transfer type
    input  wire        hwrite,                         // Write when high
    input  wire [2:0]  hsize,                          // Transfer size
    input  wire [31:0] hwdata,                         // Write data
    input  wire        hready,                         // Bus ready in
    output wire        hreadyout,                      // Slave ready
    output wire        hresp,                          // Always OKAY
    output reg  [31:0] hrdata,                         // Read data
    input  wire [2:0]  output_source_select,           // Source code from its register
    input  wire        first_neg_bypass_impedance,     // First pair impedance bit
    output wire [1:0]  pos_pin_driver_type,            // Positive pin driver code
    output wire [1:0]  neg_pin_driver_type,            // Negative pin driver code
    output wire [2:0]  pos_pin_level,                  // Positive pin level code
    output wire [2:0]  neg_pin_level,                  // Negative pin level code
    output wire        neg_bypass_impedance,           // 1 = 20 kohm
    output wire        pos_bypass_impedance,           // 1 = 20 kohm
    output wire        bypass_input_style,             // 1 = single-ended
    output wire        second_chan_bandwidth,          // 1 = 96 kHz band
    output wire        second_chan_coupling_tolerance, // 1 = AC or DC coupled
    output reg  [3:0]  pos_drive_sel,                  // One-hot positive driver
    output reg  [3:0]  neg_drive_sel,                  // One-hot negative driver
    output reg  [4:0]  pos_level_db,                   // Signed dB, zero if reserved
    output reg  [4:0]  neg_level_db                    // Signed dB, zero if reserved
);

    // ----------------------------------------
    // Decoding functions
    // ----------------------------------------
    function lane0_hit;
        input [2:0] size;
        input [1:0] low;
        begin
            case (size)
                3'h0: lane0_hit = (low == 2'h0);
                3'h1: lane0_hit = (low[1] == 1'b0);
                default: lane0_hit = 1'b1;
            endcase
        end
    endfunction

    function [3:0] drive_onehot;
        input [1:0] code;
        begin
            drive_onehot = 4'h1 << code;
        end
    endfunction

    function [4:0] level_to_db;
        input [2:0] code;
        begin
            case (code)
                `LVL_P12: level_to_db = 5'h0C;
                `LVL_P6:  level_to_db = 5'h06;
                `LVL_0:   level_to_db = 5'h00;
                `LVL_M6:  level_to_db = 5'h1A;
                `LVL_M12: level_to_db = 5'h14;
                default:  level_to_db = 5'h00;
            endcase
        end
    endfunction

    function level_reserved;
        input [2:0] code;
        begin
            level_reserved = (code < `LVL_P12) || (code > `LVL_M12);
        end
    endfunction

    // Level code against the source currently selected
    function level_allowed;
        input [2:0] code;
        input [2:0] src;
        input       imp;
        reg         byp_or_mix;
        begin
            byp_or_mix = (src == `SRC_BYP) || (src == `SRC_MIX);
            case (code)
                `LVL_P12: level_allowed = (src == `SRC_BYP);
                `LVL_P6:  level_allowed = byp_or_mix;
                `LVL_0:   level_allowed = 1'b1;
                `LVL_M6:  level_allowed = byp_or_mix;
                `LVL_M12: level_allowed = byp_or_mix && !imp;
                default:  level_allowed = 1'b0;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Address phase capture
    // ----------------------------------------
    reg        dph_valid_q;
    reg        dph_write_q;
    reg        dph_lane0_q;
    reg [31:0] dph_addr_q;

    wire addr_phase = ce && hsel && hready && htrans[1];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_valid_q <= 1'b0;
            dph_write_q <= 1'b0;
            dph_lane0_q <= 1'b0;
            dph_addr_q  <= 32'h00000000;
        end else if (ce) begin
            if (hready) begin
                dph_valid_q <= addr_phase;
                dph_write_q <= hwrite;
                dph_lane0_q <= lane0_hit(hsize, haddr[1:0]);
                dph_addr_q  <= haddr;
            end
        end
    end

    // Zero wait states; a low enable stalls the master instead of losing data
    assign hreadyout = ce;
    assign hresp     = 1'b0;

    // ----------------------------------------
    // Write strobes
    // ----------------------------------------
    wire wr_go = dph_valid_q && dph_write_q && dph_lane0_q;
    wire we_a  = wr_go && (dph_addr_q == `CFG_A_ADDR);            // see R1
    wire we_b  = wr_go && (dph_addr_q == `CFG_B_ADDR);            // see R2
    wire we_st = wr_go && (dph_addr_q == `STAT_ADDR);

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    wire [7:0] cfg_a_q;
    wire [7:0] cfg_a_nx;
    wire [7:0] cfg_b_q;
    wire [7:0] cfg_b_nx;

    cfg_byte_reg #(
        .RESET_VAL (`CFG_A_RESET),                              // see R1
        .WMASK     (`CFG_A_WMASK)
    ) u_cfg_a (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .we        (we_a),                                      // see R17
        .wdata     (hwdata[7:0]),
        .q_next    (cfg_a_nx),
        .q         (cfg_a_q)
    );

    // Bit 1 is masked off, so it always reads its reset zero
    cfg_byte_reg #(
        .RESET_VAL (`CFG_B_RESET),                              // see R2
        .WMASK     (`CFG_B_WMASK)                               // see R15
    ) u_cfg_b (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .we        (we_b),                                      // see R17
        .wdata     (hwdata[7:0]),
        .q_next    (cfg_b_nx),
        .q         (cfg_b_q)
    );

    // ----------------------------------------
    // Field outputs
    // ----------------------------------------
    assign pos_pin_driver_type = cfg_a_q[`DRV_HI:`DRV_LO];        // see R3
    assign neg_pin_driver_type = cfg_b_q[`DRV_HI:`DRV_LO];        // see R4
    assign pos_pin_level       = cfg_a_q[`LVL_HI:`LVL_LO];        // see R5
    assign neg_pin_level       = cfg_b_q[`LVL_HI:`LVL_LO];        // see R6
    assign neg_bypass_impedance           = cfg_a_q[`IMP_BIT];   // see R10
    assign pos_bypass_impedance           = cfg_b_q[`IMP_BIT];   // see R11
    assign bypass_input_style             = cfg_a_q[`STYLE_BIT]; // see R12
    assign second_chan_bandwidth          = cfg_a_q[`LOW_BIT];   // see R13
    assign second_chan_coupling_tolerance = cfg_b_q[`LOW_BIT];   // see R14

    // ----------------------------------------
    // Registered decodes per pin
    // ----------------------------------------
    wire [7:0] pin_cfg [0:1];
    wire [3:0] sel_w   [0:1];
    wire [4:0] db_w    [0:1];

    assign pin_cfg[0] = cfg_a_q;
    assign pin_cfg[1] = cfg_b_q;

    genvar gp;
    generate
        for (gp = 0; gp < 2; gp = gp + 1) begin : g_pin
            assign sel_w[gp] = drive_onehot(pin_cfg[gp][`DRV_HI:`DRV_LO]); // see R3
            assign db_w[gp]  = level_to_db(pin_cfg[gp][`LVL_HI:`LVL_LO]);  // see R5
        end
    endgenerate

    // Decodes trail the fields by one cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_drive_sel <= 4'h1;
            neg_drive_sel <= 4'h1;
            pos_level_db  <= 5'h00;
            neg_level_db  <= 5'h00;
        end else if (ce) begin
            pos_drive_sel <= sel_w[0];
            neg_drive_sel <= sel_w[1];                          // see R4
            pos_level_db  <= db_w[0];
            neg_level_db  <= db_w[1];                           // see R6
        end
    end

    // ----------------------------------------
    // Level checks against the source mode
    // ----------------------------------------
    // The device cannot refuse a bad level; it only reports it to software
    wire src_known = (output_source_select >= `SRC_DAC) &&
                     (output_source_select <= 3'h5);            // see R16
    wire pos_rsvd  = level_reserved(pos_pin_level);
    wire neg_rsvd  = level_reserved(neg_pin_level);
    wire pos_bad   = !src_known ||
                     !level_allowed(pos_pin_level, output_source_select,
                                    first_neg_bypass_impedance); // see R7
    wire neg_bad   = !src_known ||
                     !level_allowed(neg_pin_level, output_source_select,
                                    first_neg_bypass_impedance); // see R9

    // ----------------------------------------
    // Status register
    // ----------------------------------------
    reg  [3:0] live_q;
    reg        rsvd_wr_q;
    wire       rsvd_wr_set = we_b && hwdata[`RSVD_BIT];         // see R15
    wire       rsvd_wr_clr = we_st && hwdata[`ST_RSVD_WR];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            live_q    <= 4'h0;
            rsvd_wr_q <= 1'b0;
        end else if (ce) begin
            live_q    <= {neg_bad, pos_bad, neg_rsvd, pos_rsvd}; // see R8
            // A new offending write beats a clear in the same cycle
            if (rsvd_wr_set) begin
                rsvd_wr_q <= 1'b1;
            end else if (rsvd_wr_clr) begin
                rsvd_wr_q <= 1'b0;
            end
        end
    end

    wire [31:0] stat_word = {21'h00000, output_source_select, 3'h0,
                             rsvd_wr_q, live_q};

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Config register reads see the value a write in the previous data phase just made
    reg [31:0] rd_mux;

    always @* begin
        case (haddr)
            `CFG_A_ADDR: rd_mux = {24'h000000, cfg_a_nx};       // see R17
            `CFG_B_ADDR: rd_mux = {24'h000000, cfg_b_nx};       // see R17
            `STAT_ADDR:  rd_mux = stat_word;
            default:     rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_phase && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

endmodule

`default_nettype wire

// ### pkg/out_two_defs.vh
`ifndef OUT_TWO_DEFS_VH
`define OUT_TWO_DEFS_VH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define CFG_A_IDX       8'h6C
`define CFG_B_IDX       8'h6D
`define CFG_A_ADDR      32'h000001B0
`define CFG_B_ADDR      32'h000001B4
`define STAT_ADDR       32'h00000200

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define CFG_A_RESET     8'h20
`define CFG_B_RESET     8'h20
`define CFG_A_WMASK     8'hFF
`define CFG_B_WMASK     8'hFD

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DRV_HI          7
`define DRV_LO          6
`define LVL_HI          5
`define LVL_LO          3
`define IMP_BIT         2
`define STYLE_BIT       1
`define RSVD_BIT        1
`define LOW_BIT         0

// ----------------------------------------
// Level codes and output source codes
// ----------------------------------------
`define LVL_P12         3'h2
`define LVL_P6          3'h3
`define LVL_0           3'h4
`define LVL_M6          3'h5
`define LVL_M12         3'h6
`define SRC_DAC         3'h1
`define SRC_BYP         3'h2
`define SRC_MIX         3'h3

// ----------------------------------------
// Status register bits
// ----------------------------------------
`define ST_POS_RSVD     0
`define ST_NEG_RSVD     1
`define ST_POS_MISUSE   2
`define ST_NEG_MISUSE   3
`define ST_RSVD_WR      4

`endif

// ### sim/out_two_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "out_two_defs.vh"
module out_two_sva (
    input wire logic        hclk,                           // Clock
    input wire logic        hresetn,                        // Reset, low
    input wire logic        ce,                             // Enable
    input wire logic        hsel,                           // Select
    input wire logic [31:0] haddr,                          // Address
    input wire logic [1:0]  htrans,                         // Type
    input wire logic        hwrite,                         // Write
    input wire logic [2:0]  hsize,                          // Size
    input wire logic [31:0] hwdata,                         // Write data
    input wire logic        hready,                         // Ready in
    input wire logic        hreadyout,                      // Ready out
    input wire logic        hresp,                          // Response
    input wire logic [31:0] hrdata,                         // Read data
    input wire logic [1:0]  pos_pin_driver_type,            // Field
    input wire logic [1:0]  neg_pin_driver_type,            // Field
    input wire logic [2:0]  pos_pin_level,                  // Field
    input wire logic [2:0]  neg_pin_level,                  // Field
    input wire logic        neg_bypass_impedance,           // Field
    input wire logic        pos_bypass_impedance,           // Field
    input wire logic        bypass_input_style,             // Field
    input wire logic        second_chan_bandwidth,          // Field
    input wire logic        second_chan_coupling_tolerance, // Field
    input wire logic [3:0]  pos_drive_sel,                  // One-hot
    input wire logic [3:0]  neg_drive_sel,                  // One-hot
    input wire logic [4:0]  pos_level_db                    // Level dB
);
    // ----------------------------------------
    // Bus decode and properties
    // ----------------------------------------
    wire       acc  = hsel && hready && htrans[1] && ce;
    wire       rd_a = acc && !hwrite && haddr == `CFG_A_ADDR;
    wire       rd_b = acc && !hwrite && haddr == `CFG_B_ADDR;
    wire       wr_a = acc && hwrite && hsize == 3'h2 && haddr == `CFG_A_ADDR;
    wire [7:0] wlo  = hwdata[7:0];
    wire [7:0] fa   = {pos_pin_driver_type, pos_pin_level, neg_bypass_impedance,
                       bypass_input_style, second_chan_bandwidth};
    wire [7:0] fb   = {neg_pin_driver_type, neg_pin_level, pos_bypass_impedance,
                       1'b0, second_chan_coupling_tolerance};

    function automatic logic [4:0] db(input logic [2:0] c);
        case (c)
            3'h2: db = 5'h0C;
            3'h3: db = 5'h06;
            3'h5: db = 5'h1A;
            3'h6: db = 5'h14;
            default: db = 5'h00;
        endcase
    endfunction

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_HRESP: assert property (hresp == 1'b0)
        else $error("hresp not OKAY");
    AST_READY: assert property (hreadyout == ce)
        else $error("hreadyout does not follow ce");
    AST_RD_A: assert property (rd_a |=> hrdata == {24'h0, fa})
        else $error("cfg_a read differs from fields");
    AST_RD_B: assert property (rd_b |=> hrdata == {24'h0, fb})
        else $error("cfg_b read differs from fields");
    AST_WR_A: assert property (wr_a ##1 ce |=> fa == $past(wlo))
        else $error("cfg_a write not applied");
    AST_HOLD: assert property (!(acc && !hwrite) |=> $stable(hrdata))
        else $error("hrdata changed without read");
    AST_POS_SEL: assert property (ce |-> pos_drive_sel == 4'h1 << $past(pos_pin_driver_type))
        else $error("pos_drive_sel wrong");
    AST_NEG_SEL: assert property (ce |-> neg_drive_sel == 4'h1 << $past(neg_pin_driver_type))
        else $error("neg_drive_sel wrong");
    AST_POS_DB: assert property (ce |-> pos_level_db == db($past(pos_pin_level)))
        else $error("pos_level_db wrong");
endmodule
bind output_two_config_regs out_two_sva u_out_two_sva (
    .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .pos_pin_driver_type, .neg_pin_driver_type,
    .pos_pin_level, .neg_pin_level, .neg_bypass_impedance, .pos_bypass_impedance,
    .bypass_input_style, .second_chan_bandwidth, .second_chan_coupling_tolerance,
    .pos_drive_sel, .neg_drive_sel, .pos_level_db);
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "out_two_defs.vh"
module testbench;
    logic        hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0;
    logic        first_neg_bypass_impedance = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd, ad;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2, output_source_select = 3'h2; // Bypass allows every non-reserved row level
    wire         hready, hreadyout, hresp;
    wire  [31:0] hrdata;
    wire  [1:0]  pos_pin_driver_type, neg_pin_driver_type;
    wire  [2:0]  pos_pin_level, neg_pin_level;
    wire         neg_bypass_impedance, pos_bypass_impedance, bypass_input_style;
    wire         second_chan_bandwidth, second_chan_coupling_tolerance;
    wire  [3:0]  pos_drive_sel, neg_drive_sel;
    wire  [4:0]  pos_level_db, neg_level_db;
    int          failures = 0, n_tests = 0;
    wire  [7:0]  fa = {pos_pin_driver_type, pos_pin_level, neg_bypass_impedance,
                       bypass_input_style, second_chan_bandwidth};
    wire  [7:0]  fb = {neg_pin_driver_type, neg_pin_level, pos_bypass_impedance,
                       1'b0, second_chan_coupling_tolerance};
    typedef struct packed {logic b; logic [7:0] w, e; logic [3:0] s; logic [4:0] d;} row_t;
    // Covers every driver code and every level code but 4 on the positive pin; the negative pin gets drivers 1-3 and levels 4, 6, 7
    row_t rows [0:9] = '{'{0, 8'hFF, 8'hFF, 4'h8, 5'h00}, '{0, 8'h5A, 8'h5A, 4'h2, 5'h06},
        '{0, 8'h97, 8'h97, 4'h4, 5'h0C}, '{0, 8'h2C, 8'h2C, 4'h1, 5'h1A},
        '{0, 8'hF1, 8'hF1, 4'h8, 5'h14}, '{0, 8'h09, 8'h09, 4'h1, 5'h00},
        '{0, 8'h00, 8'h00, 4'h1, 5'h00}, '{1, 8'hFF, 8'hFD, 4'h8, 5'h00},
        '{1, 8'h62, 8'h60, 4'h2, 5'h00}, '{1, 8'hB5, 8'hB5, 4'h4, 5'h14}};

    assign hready = hreadyout;
    initial forever #20 hclk = ~hclk;

    output_two_config_regs u_output_two_config_regs (
        .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .output_source_select, .first_neg_bypass_impedance,
        .pos_pin_driver_type, .neg_pin_driver_type, .pos_pin_level, .neg_pin_level,
        .neg_bypass_impedance, .pos_bypass_impedance, .bypass_input_style,
        .second_chan_bandwidth, .second_chan_coupling_tolerance, .pos_drive_sel,
        .neg_drive_sel, .pos_level_db, .neg_level_db);

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask

    // Bounded so a frozen slave cannot hang the run
    task automatic wait_rdy();
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hready !== 1'b1 && i < 64);
        if (hready !== 1'b1) begin
            $display("[FAIL] hready expected 1 seen %b", hready);
            failures++;
            finish_test();
        end
    endtask

    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic rst_chk(input int n);
        hresetn <= 1'b0;
        repeat (n) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, `CFG_A_ADDR, 32'h0);
        chk("cfg_a reset", {24'h0, `CFG_A_RESET}, rd);
        xfer(1'b0, `CFG_B_ADDR, 32'h0);
        chk("cfg_b reset", {24'h0, `CFG_B_RESET}, rd);
        chk("sel reset", 32'h11, {24'h0, pos_drive_sel, neg_drive_sel});
        $display("test reset done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_chk(16);
        foreach (rows[k]) begin
            ad = rows[k].b ? `CFG_B_ADDR : `CFG_A_ADDR;
            xfer(1'b1, ad, {24'h0, rows[k].w});
            xfer(1'b0, ad, 32'h0);
            chk("readback", {24'h0, rows[k].e}, rd);
            @(negedge hclk);
            chk("fields", {24'h0, rows[k].e}, {24'h0, rows[k].b ? fb : fa});
            chk("drive_sel", {28'h0, rows[k].s},
                {28'h0, rows[k].b ? neg_drive_sel : pos_drive_sel});
            chk("level_db", {27'h0, rows[k].d},
                {27'h0, rows[k].b ? neg_level_db : pos_level_db});
            @(posedge hclk);
        end
        $display("test rows done");
        xfer(1'b0, `STAT_ADDR, 32'h0);
        chk("status sticky", 32'h215, rd & 32'h71F);
        first_neg_bypass_impedance <= 1'b1;
        xfer(1'b1, `STAT_ADDR, 32'h10);
        xfer(1'b0, `STAT_ADDR, 32'h0);
        chk("status clear", 32'h20D, rd & 32'h71F);
        output_source_select <= 3'h5;
        first_neg_bypass_impedance <= 1'b0;
        // Live bits lag the source by one edge
        repeat (2) @(posedge hclk);
        xfer(1'b0, `STAT_ADDR, 32'h0);
        chk("status source", 32'h50D, rd & 32'h71F);
        $display("test status done");
        ce <= 1'b0;
        fork
            xfer(1'b1, `CFG_A_ADDR, 32'h24);
            begin
                repeat (4) @(posedge hclk);
                chk("stall", 32'h0, {31'h0, hreadyout});
                ce <= 1'b1;
            end
        join
        xfer(1'b1, 32'h1B8, 32'hFF);
        xfer(1'b0, 32'h1B8, 32'h0);
        chk("unmapped", 32'h0, rd);
        xfer(1'b0, `CFG_A_ADDR, 32'h0);
        chk("cfg_a kept", 32'h24, rd);
        $display("test stall done");
        rst_chk(2);
        finish_test();
    end
endmodule
`default_nettype wire
